// [logic/sr_defines.svh]
`ifndef SR_DEFINES_SVH
`define SR_DEFINES_SVH

// ****************************************************************
// clock rates
// ****************************************************************
`define SR_SYS_CLK_HZ   10000000
`define SR_MCLK_HZ      32768
`define SR_MCLK_HALF    (`SR_SYS_CLK_HZ / (2 * `SR_MCLK_HZ))

// ****************************************************************
// instruction framing
// ****************************************************************
`define SR_START_PAT    3'h7
`define SR_STOP_PAT     3'h0
`define SR_SETUP_W      4
`define SR_INST_LEN     10
`define SR_RST_LEN      21
`define SR_FRAME_LEN    31
`define SR_FRAME_MSB    30

// ****************************************************************
// readout counts
// ****************************************************************
`define SR_DATA_W       16
`define SR_READ_CLKS    5'h11
`define SR_EXTRA_CLKS   5'h02
`define SR_CNT_ONE      5'h01
`define SR_CNT_ZERO     5'h00

`endif

// [logic/sr_pkg.sv]
`default_nettype none

package sr_pkg;

  typedef enum logic [2:0] {
    cmd_pressure_conversion    = 3'h0,
    cmd_temperature_conversion = 3'h1,
    cmd_cal_slot_one           = 3'h2,
    cmd_cal_slot_two           = 3'h3,
    cmd_cal_slot_three         = 3'h4,
    cmd_cal_slot_four          = 3'h5,
    cmd_reset                  = 3'h6
  } cmd_e;

  typedef enum logic [2:0] {
    st_idle  = 3'h0,
    st_send  = 3'h1,
    st_ack   = 3'h2,
    st_extra = 3'h3,
    st_wait  = 3'h4,
    st_read  = 3'h5
  } state_e;

endpackage

`default_nettype wire

// [logic/tick_divider.sv]
`timescale 1ns/1ns
`default_nettype none

module tick_divider #(
  parameter int HALF = 4
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic sys_rst,
  // control
  input  wire logic run,
  // tick
  output logic      tick
);

  localparam int CW = $clog2(HALF + 1);

  logic [CW-1:0] cnt_q;
  wire           at_end;

  if (HALF < 1) begin : g_chk
    $error("tick_divider: HALF must be at least one");
  end

  assign at_end = (cnt_q == CW'(HALF - 1));
  assign tick   = run & at_end;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_q <= '0;
    end else if (!run || at_end) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_q + CW'(1);
    end
  end

endmodule

`default_nettype wire

// [logic/pin_sync.sv]
`timescale 1ns/1ns
`default_nettype none

module pin_sync (
  // clock and reset
  input  wire logic clk,
  input  wire logic sys_rst,
  // pin and synchronised level
  input  wire logic pin,
  output logic      level
);

  logic meta_q;
  logic level_q;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      meta_q  <= 1'b0;
      level_q <= 1'b0;
    end else begin
      meta_q  <= pin;
      level_q <= meta_q;
    end
  end

  assign level = level_q;

endmodule

`default_nettype wire

// [logic/sensor_host.sv]
`timescale 1ns/1ns
`default_nettype none
`include "sr_defines.svh"

// Notes on behaviour
// R1 - sensor samples and launches on rising edge
// R2 - host samples and changes data on fall
// R3 - host alone generates the shift clock
// R4 - last instruction selects result or calibration
// R5 - output line also shows conversion status
// R6 - pressure, temperature, four calibration, reset instructions
// R7 - every transaction opens with instruction, no select; code opens reset and reset-first transactions with the reset pattern
// R8 - three high start bits before setup
// R9 - three low stop bits after setup
// R10 - four bit setup field selects operation
// R11 - sensor raises output to acknowledge conversion
// R12 - two more clocks after acknowledge
// R13 - clock held low until output falls
// R14 - seventeen clocks shift out sixteen bits
// R15 - readout may pause by holding clock
// R16 - read result fully before next conversion
// R17 - reset pattern resynchronises from any state
// R18 - reset pattern is twenty one bits
// R19 - output ignored while reset shifts in
// R20 - reset may precede each conversion instruction
// R21 - sixty four bit factory calibration memory
// R22 - calibration memory is four sixteen bit words
// R23 - host drives converter clock at 32.768 kHz; code toggles every 152 cycles of the 10 MHz clock, about 32.9 kHz
// R24 - setup codes and reset pattern are parameters
// R25 - conversion duration configurable, host waits bounded
module sensor_host #(
  parameter int          SCLK_HALF      = 4,
  parameter int          MCLK_HALF      = `SR_MCLK_HALF,
  parameter int          ACK_MAX_CLKS   = 16,
  parameter int          CONV_TIMEOUT   = 1000000,
  parameter logic [3:0]  CODE_PRESSURE  = 4'hA,
  parameter logic [3:0]  CODE_TEMP      = 4'h9,
  parameter logic [3:0]  CODE_CAL_ONE   = 4'h5,
  parameter logic [3:0]  CODE_CAL_TWO   = 4'h6,
  parameter logic [3:0]  CODE_CAL_THREE = 4'h3,
  parameter logic [3:0]  CODE_CAL_FOUR  = 4'hC,
  parameter logic [20:0] RESET_PATTERN  = 21'h0AAAAA
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         sys_rst,
  // command
  input  wire logic         cmd_valid,
  output logic              cmd_ready,
  input  wire sr_pkg::cmd_e cmd_code,
  input  wire logic         cmd_reset_first,
  // readout pause
  input  wire logic         read_hold,
  // result
  output logic              res_valid,
  output logic [15:0]       res_data,
  output sr_pkg::cmd_e      res_kind,
  output logic              res_error,
  // sensor pins
  output logic              sclk,
  output logic              din,
  output logic              mclk,
  input  wire logic         dout
);

  // ****************************************************************
  // elaboration checks
  // ****************************************************************
  localparam int WW = $clog2(CONV_TIMEOUT + 1);

  if (SCLK_HALF < 3) begin : g_chk_sclk
    $error("sensor_host: SCLK_HALF must cover the input synchroniser");
  end
  if (ACK_MAX_CLKS < 1 || ACK_MAX_CLKS > 31) begin : g_chk_ack
    $error("sensor_host: ACK_MAX_CLKS must be 1 to 31");
  end
  if (CONV_TIMEOUT < 1) begin : g_chk_tmo
    $error("sensor_host: CONV_TIMEOUT must be at least one");
  end

  // ****************************************************************
  // state
  // ****************************************************************
  sr_pkg::state_e            state_q;
  sr_pkg::state_e            state_d;
  sr_pkg::cmd_e              kind_q;
  sr_pkg::cmd_e              kind_d;
  logic [`SR_FRAME_MSB:0]    tx_q;
  logic [`SR_FRAME_MSB:0]    tx_d;
  logic [4:0]                cnt_q;
  logic [4:0]                cnt_d;
  logic [WW-1:0]             wait_q;
  logic [WW-1:0]             wait_d;
  logic [`SR_DATA_W-1:0]     rx_q;
  logic [`SR_DATA_W-1:0]     rx_d;
  logic                      din_q;
  logic                      din_d;
  logic                      sclk_q;
  logic                      mclk_q;
  logic                      res_valid_q;
  logic                      res_valid_d;
  logic [`SR_DATA_W-1:0]     res_data_q;
  logic [`SR_DATA_W-1:0]     res_data_d;
  logic                      res_error_q;
  logic                      res_error_d;
  sr_pkg::cmd_e              res_kind_q;
  sr_pkg::cmd_e              res_kind_d;

  // ****************************************************************
  // pin input synchroniser and dividers
  // ****************************************************************
  wire dout_s;
  wire sclk_tick;
  wire mclk_tick;
  wire clk_run;

  pin_sync u_dout_sync (
    .clk     (clk),
    .sys_rst (sys_rst),
    .pin     (dout),
    .level   (dout_s)
  );

  tick_divider #(
    .HALF (SCLK_HALF)
  ) u_sclk_div (
    .clk     (clk),
    .sys_rst (sys_rst),
    .run     (clk_run),
    .tick    (sclk_tick)
  );

  tick_divider #(
    .HALF (MCLK_HALF)
  ) u_mclk_div (
    .clk     (clk),
    .sys_rst (sys_rst),
    .run     (1'b1),
    .tick    (mclk_tick)
  );

  // ****************************************************************
  // decode
  // ****************************************************************
  wire                     in_send;
  wire                     in_ack;
  wire                     in_extra;
  wire                     in_read;
  wire                     read_pause;
  wire                     rise;
  wire                     fall;
  wire                     last_bit;
  wire                     is_reset_cmd;
  wire                     is_conv_cmd;
  wire                     kind_reset;
  wire                     kind_conv;
  wire                     ack_limit;
  wire                     wait_limit;
  wire [3:0]               setup_code;
  wire [`SR_INST_LEN-1:0]  inst_bits;
  wire [`SR_FRAME_MSB:0]   load_frame;
  wire [4:0]               load_cnt;

  assign in_send    = (state_q == sr_pkg::st_send);
  assign in_ack     = (state_q == sr_pkg::st_ack);
  assign in_extra   = (state_q == sr_pkg::st_extra);
  assign in_read    = (state_q == sr_pkg::st_read);
  assign read_pause = in_read & read_hold & ~sclk_q;                           // see R15
  // shift clock runs only while this end clocks a transfer
  assign clk_run    = in_send | in_ack | in_extra | (in_read & ~read_pause);   // see R3
  assign rise       = sclk_tick & ~sclk_q;
  assign fall       = sclk_tick & sclk_q;                                      // see R2
  assign last_bit   = (cnt_q == `SR_CNT_ONE);

  assign is_reset_cmd = (cmd_code == sr_pkg::cmd_reset);
  assign is_conv_cmd  = (cmd_code == sr_pkg::cmd_pressure_conversion) |
                        (cmd_code == sr_pkg::cmd_temperature_conversion);
  assign kind_reset   = (kind_q == sr_pkg::cmd_reset);
  assign kind_conv    = (kind_q == sr_pkg::cmd_pressure_conversion) |
                        (kind_q == sr_pkg::cmd_temperature_conversion);
  assign ack_limit    = (cnt_q == 5'(ACK_MAX_CLKS - 1));
  assign wait_limit   = (wait_q == WW'(CONV_TIMEOUT - 1));

  // setup field per instruction
  assign setup_code =
    (cmd_code == sr_pkg::cmd_pressure_conversion)    ? CODE_PRESSURE  :
    (cmd_code == sr_pkg::cmd_temperature_conversion) ? CODE_TEMP      :
    (cmd_code == sr_pkg::cmd_cal_slot_one)           ? CODE_CAL_ONE   :
    (cmd_code == sr_pkg::cmd_cal_slot_two)           ? CODE_CAL_TWO   :
    (cmd_code == sr_pkg::cmd_cal_slot_three)         ? CODE_CAL_THREE :
                                                       CODE_CAL_FOUR;      // see R6 R10 R24 R22

  // start, setup, stop framing
  assign inst_bits = {`SR_START_PAT, setup_code, `SR_STOP_PAT};           // see R8 R9 R7

  // frame is left aligned, the reset pattern goes first when asked
  assign load_frame =
    is_reset_cmd    ? {RESET_PATTERN, {`SR_INST_LEN{1'b0}}} :
    cmd_reset_first ? {RESET_PATTERN, inst_bits}            :
                      {inst_bits, {`SR_RST_LEN{1'b0}}};                    // see R18 R20 R17

  assign load_cnt =
    is_reset_cmd    ? 5'(`SR_RST_LEN)   :
    cmd_reset_first ? 5'(`SR_FRAME_LEN) :
                      5'(`SR_INST_LEN);

  // ****************************************************************
  // sequencer
  // ****************************************************************
  always_comb begin
    state_d     = state_q;
    kind_d      = kind_q;
    tx_d        = tx_q;
    cnt_d       = cnt_q;
    wait_d      = wait_q;
    rx_d        = rx_q;
    din_d       = din_q;
    res_valid_d = 1'b0;
    res_data_d  = res_data_q;
    res_error_d = res_error_q;
    res_kind_d  = res_kind_q;
    unique case (state_q)
      sr_pkg::st_idle: begin
        // one transaction at a time, so no conversion starts early
        if (cmd_valid) begin                                               // see R16
          state_d = sr_pkg::st_send;
          kind_d  = cmd_code;
          tx_d    = load_frame;
          cnt_d   = load_cnt;
          din_d   = load_frame[`SR_FRAME_MSB];
        end
      end
      sr_pkg::st_send: begin
        // output line is not looked at while bits go out
        if (fall) begin                                                    // see R19 R2
          tx_d  = {tx_q[`SR_FRAME_MSB-1:0], 1'b0};
          din_d = tx_q[`SR_FRAME_MSB-1];
          cnt_d = cnt_q - `SR_CNT_ONE;
          if (last_bit) begin
            din_d = 1'b0;
            if (kind_reset) begin
              state_d     = sr_pkg::st_idle;
              res_valid_d = 1'b1;
              res_error_d = 1'b0;
              res_kind_d  = kind_q;
            end else if (kind_conv) begin
              state_d = sr_pkg::st_ack;
              cnt_d   = `SR_CNT_ZERO;
            end else begin
              state_d = sr_pkg::st_read;
              cnt_d   = `SR_READ_CLKS;                                     // see R4 R21
            end
          end
        end
      end
      sr_pkg::st_ack: begin
        // keep clocking until the output line goes high or ACK_MAX_CLKS clocks pass
        if (fall) begin                                                    // see R11 R5
          if (dout_s) begin
            state_d = sr_pkg::st_extra;
            cnt_d   = `SR_EXTRA_CLKS;
          end else if (ack_limit) begin
            state_d     = sr_pkg::st_idle;
            res_valid_d = 1'b1;
            res_error_d = 1'b1;
            res_kind_d  = kind_q;
          end else begin
            cnt_d = cnt_q + `SR_CNT_ONE;
          end
        end
      end
      sr_pkg::st_extra: begin
        if (fall) begin                                                    // see R12
          cnt_d = cnt_q - `SR_CNT_ONE;
          if (last_bit) begin
            state_d = sr_pkg::st_wait;
            wait_d  = '0;
          end
        end
      end
      sr_pkg::st_wait: begin
        // clock stays low; the falling output ends the conversion
        if (!dout_s) begin                                                 // see R13 R5
          state_d = sr_pkg::st_read;
          cnt_d   = `SR_READ_CLKS;
        end else if (wait_limit) begin                                     // see R25
          state_d     = sr_pkg::st_idle;
          res_valid_d = 1'b1;
          res_error_d = 1'b1;
          res_kind_d  = kind_q;
        end else begin
          wait_d = wait_q + WW'(1);
        end
      end
      sr_pkg::st_read: begin
        // sixteen data bits msb first, then one trailing clock
        if (fall) begin                                                    // see R14 R1
          cnt_d = cnt_q - `SR_CNT_ONE;
          if (!last_bit) begin
            rx_d = {rx_q[`SR_DATA_W-2:0], dout_s};
          end else begin
            state_d     = sr_pkg::st_idle;
            res_valid_d = 1'b1;
            res_data_d  = rx_q;
            res_error_d = 1'b0;
            res_kind_d  = kind_q;
          end
        end
      end
      default: begin
        state_d = sr_pkg::st_idle;
      end
    endcase
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_q <= sr_pkg::st_idle;
      kind_q  <= sr_pkg::cmd_reset;
      tx_q    <= '0;
      cnt_q   <= '0;
      wait_q  <= '0;
      rx_q    <= '0;
      din_q   <= 1'b0;
    end else begin
      state_q <= state_d;
      kind_q  <= kind_d;
      tx_q    <= tx_d;
      cnt_q   <= cnt_d;
      wait_q  <= wait_d;
      rx_q    <= rx_d;
      din_q   <= din_d;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      res_valid_q <= 1'b0;
      res_data_q  <= '0;
      res_error_q <= 1'b0;
      res_kind_q  <= sr_pkg::cmd_reset;
    end else begin
      res_valid_q <= res_valid_d;
      res_data_q  <= res_data_d;
      res_error_q <= res_error_d;
      res_kind_q  <= res_kind_d;
    end
  end

  // shift clock: rise then fall on each half period tick
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sclk_q <= 1'b0;
    end else if (rise) begin
      sclk_q <= 1'b1;
    end else if (fall) begin
      sclk_q <= 1'b0;
    end
  end

  // free running converter clock
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      mclk_q <= 1'b0;
    end else if (mclk_tick) begin
      mclk_q <= ~mclk_q;                                                   // see R23
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign cmd_ready = (state_q == sr_pkg::st_idle);
  assign res_valid = res_valid_q;
  assign res_data  = res_data_q;
  assign res_kind  = res_kind_q;
  assign res_error = res_error_q;
  assign sclk      = sclk_q;
  assign din       = din_q;
  assign mclk      = mclk_q;

endmodule

`default_nettype wire

// [testbench/sensor_host_properties.sv]
`timescale 1ns/1ns
`default_nettype none

module sensor_host_checker #(
  parameter int          SCLK_HALF      = 4,
  parameter int          MCLK_HALF      = 152,
  parameter logic [3:0]  CODE_PRESSURE  = 4'hA,
  parameter logic [3:0]  CODE_TEMP      = 4'h9,
  parameter logic [3:0]  CODE_CAL_ONE   = 4'h5,
  parameter logic [3:0]  CODE_CAL_TWO   = 4'h6,
  parameter logic [3:0]  CODE_CAL_THREE = 4'h3,
  parameter logic [3:0]  CODE_CAL_FOUR  = 4'hC,
  parameter logic [20:0] RESET_PATTERN  = 21'h0AAAAA
) (
  // clock and reset
  input wire logic         clk,
  input wire logic         sys_rst,
  // command and result
  input wire logic         cmd_valid,
  input wire logic         cmd_ready,
  input wire sr_pkg::cmd_e cmd_code,
  input wire logic         cmd_reset_first,
  input wire logic         res_valid,
  input wire logic         res_error,
  // sensor pins
  input wire logic         sclk,
  input wire logic         din,
  input wire logic         mclk,
  input wire logic         dout
);
  // ****************************************************************
  // helper logic
  // ****************************************************************
  logic             sclk_q, mclk_q, seen_q, rf_q;
  logic [7:0]       rc_q, hi_q;
  logic [9:0]       mc_q;
  logic [29:0]      sh_q;
  logic [3:0]       code_q;
  sr_pkg::cmd_e     kind_q;
  wire logic [23:0] codes = {CODE_CAL_FOUR, CODE_CAL_THREE, CODE_CAL_TWO,
                             CODE_CAL_ONE, CODE_TEMP, CODE_PRESSURE};
  wire logic        rise = sclk && !sclk_q;
  wire logic        conv = kind_q[2:1] == 2'h0;
  wire logic [7:0]  flen = rf_q ? 8'h1F : 8'h0A;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      {sclk_q, mclk_q, seen_q, rf_q, rc_q, hi_q, mc_q, sh_q, code_q} <= '0;
      kind_q <= sr_pkg::cmd_reset;
    end else begin
      sclk_q <= sclk;
      mclk_q <= mclk;
      hi_q <= sclk ? hi_q + 8'h01 : 8'h00;
      mc_q <= (mclk != mclk_q) ? 10'h000 : mc_q + 10'h001;
      seen_q <= seen_q || (mclk != mclk_q);
      if (cmd_valid && cmd_ready) begin
        rc_q <= 8'h00;
        rf_q <= cmd_reset_first;
        kind_q <= cmd_code;
        code_q <= codes[4*cmd_code +: 4];
      end else if (rise) begin
        rc_q <= rc_q + 8'h01;
        sh_q <= {sh_q[28:0], din};
      end
    end
  end

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  din_hold_a: assert property (sclk |-> $stable(din))
    else $error("data in moved while shift clock high");
  idle_low_a: assert property (cmd_ready |-> !sclk)
    else $error("shift clock high while idle");
  clock_high_a: assert property ($fell(sclk) |-> hi_q == SCLK_HALF)
    else $error("shift clock high time wrong");
  frame_bits_a: assert property (rise && kind_q != sr_pkg::cmd_reset
    && rc_q == flen - 8'h01 |-> {sh_q[8:0], din} == {3'h7, code_q, 3'h0})
    else $error("instruction frame bits wrong");
  reset_bits_a: assert property (rise && (rf_q || kind_q == sr_pkg::cmd_reset)
    && rc_q == 8'h14 |-> {sh_q[19:0], din} == RESET_PATTERN)
    else $error("reset pattern bits wrong");
  read_count_a: assert property (res_valid && !res_error
    && kind_q != sr_pkg::cmd_reset |-> rc_q == flen + (conv ? 8'h14 : 8'h11))
    else $error("shift clock count of transfer wrong");
  wait_low_a: assert property (conv && rc_q == flen + 8'h03
    && dout && !sclk |=> !sclk)
    else $error("shift clock moved during conversion");
  ready_back_a: assert property ($rose(cmd_ready) |-> res_valid || $past(res_valid))
    else $error("idle before transfer completed");
  mclk_rate_a: assert property (mclk != mclk_q && seen_q |-> mc_q == MCLK_HALF - 1)
    else $error("converter clock rate wrong");
endmodule

bind sensor_host sensor_host_checker #(
  .SCLK_HALF(SCLK_HALF), .MCLK_HALF(MCLK_HALF), .CODE_PRESSURE(CODE_PRESSURE),
  .CODE_TEMP(CODE_TEMP), .CODE_CAL_ONE(CODE_CAL_ONE), .CODE_CAL_TWO(CODE_CAL_TWO),
  .CODE_CAL_THREE(CODE_CAL_THREE), .CODE_CAL_FOUR(CODE_CAL_FOUR),
  .RESET_PATTERN(RESET_PATTERN)
) chk_u (
  .clk(clk), .sys_rst(sys_rst), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
  .cmd_code(cmd_code), .cmd_reset_first(cmd_reset_first), .res_valid(res_valid),
  .res_error(res_error), .sclk(sclk), .din(din), .mclk(mclk), .dout(dout)
);

`default_nettype wire

// [testbench/sensor_model.sv]
`timescale 1ns/1ns
`default_nettype none

module sensor_model #(
  parameter logic [95:0] WORDS         = 96'h0,
  parameter logic [23:0] CODES         = 24'hC3659A,
  parameter logic [20:0] RESET_PATTERN = 21'h0AAAAA
) (
  // sensor pins
  input  wire logic       sclk,
  input  wire logic       din,
  input  wire logic       mclk,
  output logic            dout,
  // conversion length in converter clocks, zero mutes the acknowledge
  input  wire logic [7:0] conv_len
);
  // ****************************************************************
  // shift and state
  // ****************************************************************
  typedef enum logic [2:0] {m_idle, m_ack, m_extra, m_conv, m_read} mstate_e;
  mstate_e          st_q  = m_idle;
  logic [20:0]      sh_q  = 21'h000000;
  logic [7:0]       cnt_q = 8'h00;
  logic [4:0]       bit_q = 5'h00;
  logic [2:0]       sel_q = 3'h0;
  logic             dq_q  = 1'b0;
  wire logic [20:0] sh_d  = {sh_q[19:0], din};
  wire logic        done  = cnt_q >= conv_len;

  always @(posedge mclk) cnt_q <= (st_q == m_conv) ? cnt_q + 8'h01 : 8'h00;
  assign dout = (st_q == m_conv) ? !done : dq_q;

  always @(posedge sclk) begin
    sh_q <= sh_d;
    dq_q <= !dq_q;
    if (sh_d == RESET_PATTERN) begin
      st_q <= m_idle;
      sh_q <= 21'h000000;
    end else begin
      case (st_q)
        m_idle: begin
          for (int i = 0; i < 6; i++) begin
            if (sh_d[9:0] == {3'h7, CODES[i*4 +: 4], 3'h0}) begin
              sel_q <= i[2:0];
              sh_q <= 21'h000000;
              bit_q <= 5'h00;
              dq_q <= 1'b0;
              st_q <= (i < 2) ? m_ack : m_read;
            end
          end
        end
        m_ack: begin
          dq_q <= conv_len != 8'h00;
          st_q <= (conv_len != 8'h00) ? m_extra : m_ack;
        end
        m_extra: begin
          dq_q <= 1'b1;
          bit_q <= bit_q + 5'h01;
          st_q <= (bit_q == 5'h01) ? m_conv : m_extra;
        end
        m_conv: begin
          if (done) begin
            st_q <= m_read;
            bit_q <= 5'h01;
            dq_q <= WORDS[16*sel_q + 15];
          end
        end
        default: begin
          st_q <= (bit_q == 5'h10) ? m_idle : m_read;
          bit_q <= bit_q + 5'h01;
          if (bit_q != 5'h10) dq_q <= WORDS[16*sel_q + 15 - bit_q];
        end
      endcase
    end
  end
endmodule

`default_nettype wire

// [testbench/sensor_host_tb.sv]
`timescale 1ns/1ns
`default_nettype none

module sensor_host_tb;
  localparam logic [95:0] WORDS = 96'h4C1D_93E7_2B58_A6F0_7FFE_8001;
  // ****************************************************************
  // signals and instances
  // ****************************************************************
  logic         clk = 1'b0;
  logic         sys_rst = 1'b1;
  logic         cmd_valid = 1'b0;
  sr_pkg::cmd_e cmd_code = sr_pkg::cmd_reset;
  logic         cmd_reset_first = 1'b0;
  logic         read_hold = 1'b0;
  logic [7:0]   conv_len = 8'h01;
  logic         cmd_ready, res_valid, res_error, sclk, din, mclk, dout;
  logic [15:0]  res_data;
  sr_pkg::cmd_e res_kind;
  int           num_errors = 0;
  int           comparisons = 0;

  sensor_host #(.CONV_TIMEOUT(2000)) dut_u (
    .clk(clk), .sys_rst(sys_rst), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .cmd_code(cmd_code), .cmd_reset_first(cmd_reset_first), .read_hold(read_hold),
    .res_valid(res_valid), .res_data(res_data), .res_kind(res_kind),
    .res_error(res_error), .sclk(sclk), .din(din), .mclk(mclk), .dout(dout)
  );
  sensor_model #(.WORDS(WORDS)) model_u (
    .sclk(sclk), .din(din), .mclk(mclk), .dout(dout), .conv_len(conv_len)
  );

  initial begin
    forever #50 clk = ~clk;
  end

  // ****************************************************************
  // shared tasks
  // ****************************************************************
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic run(input sr_pkg::cmd_e code, input logic rf);
    int n;
    @(negedge clk);
    cmd_valid = 1'b1;
    cmd_code = code;
    cmd_reset_first = rf;
    @(negedge clk);
    cmd_valid = 1'b0;
    n = 0;
    while (res_valid !== 1'b1 && n < 8000) begin
      @(negedge clk);
      n++;
    end
    check({15'h0000, res_valid}, 16'h0001);
  endtask

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_idle();
    check({9'h000, res_valid, res_error, cmd_ready, sclk, res_kind}, {9'h000, 4'h2, 3'h6});
    $display("idle state done");
  endtask

  task automatic t_cal();
    for (int i = 2; i < 6; i++) begin
      run(sr_pkg::cmd_e'(i), 1'b0);
      check(res_data, WORDS[16*i +: 16]);
      check({12'h000, res_error, res_kind}, {13'h0000, i[2:0]});
    end
    $display("calibration reads done");
  endtask

  task automatic t_conv();
    for (int i = 0; i < 4; i++) begin
      conv_len = i[1] ? 8'h04 : 8'h01;
      run(sr_pkg::cmd_e'(i % 2), i[0] ^ i[1]);
      check(res_data, WORDS[16*(i%2) +: 16]);
      check({12'h000, res_error, res_kind}, {15'h0000, i[0]});
    end
    $display("conversions done");
  endtask

  task automatic t_reset();
    run(sr_pkg::cmd_reset, 1'b0);
    check(res_data, WORDS[16 +: 16]);
    check({12'h000, res_error, res_kind}, {13'h0000, 3'h6});
    $display("reset command done");
  endtask

  task automatic t_hold();
    logic hi;
    hi = 1'b0;
    fork
      run(sr_pkg::cmd_cal_slot_three, 1'b0);
      begin
        repeat (150) @(negedge clk);
        read_hold = 1'b1;
        repeat (8) @(negedge clk);
        repeat (80) begin
          @(negedge clk);
          hi = hi | sclk;
        end
        read_hold = 1'b0;
      end
    join
    check({15'h0000, hi}, 16'h0000);
    check(res_data, WORDS[64 +: 16]);
    $display("paused readout done");
  endtask

  task automatic t_errors();
    conv_len = 8'h00;
    run(sr_pkg::cmd_pressure_conversion, 1'b0);
    check({15'h0000, res_error}, 16'h0001);
    check(res_data, WORDS[64 +: 16]);
    conv_len = 8'h01;
    run(sr_pkg::cmd_pressure_conversion, 1'b1);
    check({15'h0000, res_error}, 16'h0000);
    check(res_data, WORDS[0 +: 16]);
    conv_len = 8'h0A;
    run(sr_pkg::cmd_temperature_conversion, 1'b0);
    check({15'h0000, res_error}, 16'h0001);
    run(sr_pkg::cmd_cal_slot_four, 1'b1);
    check(res_data, WORDS[80 +: 16]);
    $display("error recovery done");
  endtask

  initial begin
    repeat (5) @(negedge clk);
    sys_rst = 1'b0;
    t_idle();
    t_cal();
    t_conv();
    t_reset();
    t_hold();
    t_errors();
    end_sim();
  end

  initial begin
    repeat (30000) @(posedge clk);
    num_errors++;
    end_sim();
  end
endmodule

`default_nettype wire
